/* bench/glb_regs_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module glb_regs_monitor
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [10:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic [15:0] error_count,
    input wire logic [11:0] positive_peak,
    input wire logic [11:0] negative_peak,
    input wire logic soft_reset,
    input wire logic jitter_halt_bit,
    input wire logic jitter_mode_bit,
    input wire logic jitter_bandwidth_bit,
    input wire logic copy_ctrl,
    input wire logic [1:0] int_pin_drive
);
    logic [15:0] err_q;
    logic [11:0] pos_q;
    logic [11:0] neg_q;
    logic [7:0] wd_q;
    // Copies of the sampled inputs, compared one cycle later
    always_ff @(posedge core_clk)
    begin
        err_q <= error_count;
        pos_q <= positive_peak;
        neg_q <= negative_peak;
        wd_q <= wdata;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_rst_wr; wr_en && addr == glb_regs_pkg::SOFT_RESET_OFS; endsequence
    property p_srst; s_rst_wr |=> soft_reset; endproperty
    property p_srst_len; $rose(soft_reset) |-> ##[1:124] !soft_reset; endproperty
    property p_rd_id; rd_en && addr == glb_regs_pkg::PART_CODE_OFS |=> rdata == glb_regs_pkg::PART_CODE_VALUE; endproperty
    property p_rd_wo; rd_en && addr == glb_regs_pkg::SOFT_RESET_OFS |=> rdata == 8'h00; endproperty
    property p_err_lo; rd_en && addr == glb_regs_pkg::ERR_LOW_OFS |=> rdata == err_q[7:0]; endproperty
    property p_pos_hi; rd_en && addr == glb_regs_pkg::POS_HIGH_OFS |=> rdata == {4'h0, pos_q[11:8]}; endproperty
    property p_neg_lo; rd_en && addr == glb_regs_pkg::NEG_LOW_OFS |=> rdata == neg_q[7:0]; endproperty
    property p_gcf; wr_en && addr == glb_regs_pkg::GLOBAL_CONFIG_OFS |=> {copy_ctrl, int_pin_drive} == wd_q[4:2];
    endproperty
    property p_jm; wr_en && addr == glb_regs_pkg::JITTER_CONFIG_OFS
        |=> {jitter_halt_bit, jitter_mode_bit, jitter_bandwidth_bit} == wd_q[2:0]; endproperty
    a_srst: assert property (p_srst) else $error("soft reset not started");
    a_srst_len: assert property (p_srst_len) else $error("soft reset too long");
    a_rd_id: assert property (p_rd_id) else $error("part code wrong");
    a_rd_wo: assert property (p_rd_wo) else $error("reset register read not zero");
    a_err_lo: assert property (p_err_lo) else $error("error count low wrong");
    a_pos_hi: assert property (p_pos_hi) else $error("positive peak high wrong");
    a_neg_lo: assert property (p_neg_lo) else $error("negative peak low wrong");
    a_gcf: assert property (p_gcf) else $error("global config fields wrong");
    a_jm: assert property (p_jm) else $error("jitter config bits wrong");
endmodule
bind global_control_and_measurement_regs glb_regs_monitor u_mon (.core_clk(core_clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .error_count(error_count),
    .positive_peak(positive_peak), .negative_peak(negative_peak), .soft_reset(soft_reset),
    .jitter_halt_bit(jitter_halt_bit), .jitter_mode_bit(jitter_mode_bit),
    .jitter_bandwidth_bit(jitter_bandwidth_bit), .copy_ctrl(copy_ctrl), .int_pin_drive(int_pin_drive));
`default_nettype wire

/* bench/test_global_control_and_measurement_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module test_global_control_and_measurement_regs;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [10:0] addr = 11'h000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [15:0] error_count = 16'hA55A;
    logic [11:0] positive_peak = 12'hBCD;
    logic [11:0] negative_peak = 12'h321;
    logic [27:0] channel_mask = 28'h0F0F0F0;
    logic [27:0] channel_status = 28'hFFFFFFF;
    logic [27:0] channel_irq;
    logic timer_irq, soft_reset, jh, jmd, jbw, copy_ctrl;
    logic [1:0] int_pin_drive;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    always #4 core_clk = ~core_clk;
    // Short timer period keeps the run brief
    global_control_and_measurement_regs #(.CHANNELS(28), .ONE_SECOND_CYCLES(50)) u_dut (.core_clk(core_clk),
        .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .error_count(error_count), .positive_peak(positive_peak), .negative_peak(negative_peak),
        .channel_mask(channel_mask), .channel_status(channel_status), .channel_irq(channel_irq),
        .timer_irq(timer_irq), .soft_reset(soft_reset), .jitter_halt_bit(jh), .jitter_mode_bit(jmd),
        .jitter_bandwidth_bit(jbw), .copy_ctrl(copy_ctrl), .int_pin_drive(int_pin_drive));
    task automatic end_of_test;
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [10:0] a, input logic [7:0] e);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 chk("rdata", {24'h0, rdata}, {24'h0, e});
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        rd(glb_regs_pkg::PART_CODE_OFS, glb_regs_pkg::PART_CODE_VALUE);
        rd(glb_regs_pkg::GLOBAL_CONFIG_OFS, 8'h01);
        rd(glb_regs_pkg::ERR_LOW_OFS, 8'h5A);
        rd(glb_regs_pkg::ERR_HIGH_OFS, 8'hA5);
        rd(glb_regs_pkg::POS_LOW_OFS, 8'hCD);
        rd(glb_regs_pkg::POS_HIGH_OFS, 8'h0B);
        rd(glb_regs_pkg::NEG_LOW_OFS, 8'h21);
        rd(glb_regs_pkg::NEG_HIGH_OFS, 8'h03);
        rd(glb_regs_pkg::SOFT_RESET_OFS, 8'h00);
        wr(glb_regs_pkg::JITTER_CONFIG_OFS, 8'hFF);
        rd(glb_regs_pkg::JITTER_CONFIG_OFS, 8'h07);
        chk("jitter bits", {29'h0, jh, jmd, jbw}, 32'h7);
        wr(glb_regs_pkg::GLOBAL_CONFIG_OFS, 8'hFF);
        rd(glb_regs_pkg::GLOBAL_CONFIG_OFS, 8'h1F);
        chk("config fields", {29'h0, copy_ctrl, int_pin_drive}, 32'h7);
        chk("irq masked", {4'h0, channel_irq}, 32'h0);
        repeat (60) @(posedge core_clk);
        #1 chk("timer masked", {31'h0, timer_irq}, 32'h0);
        wr(glb_regs_pkg::GLOBAL_CONFIG_OFS, 8'h00);
        repeat (2) @(posedge core_clk);
        #1 chk("irq", {4'h0, channel_irq}, 32'h0F0F0F0F);
        repeat (110) @(posedge core_clk);
        #1 chk("timer flag", {31'h0, timer_irq}, 32'h1);
        rd(glb_regs_pkg::TIMER_STATUS_OFS, 8'h01);
        wr(glb_regs_pkg::SOFT_RESET_OFS, 8'h00);
        #1 chk("soft reset", {31'h0, soft_reset}, 32'h1);
        repeat (124) @(posedge core_clk);
        #1 chk("soft reset end", {31'h0, soft_reset}, 32'h0);
        rd(glb_regs_pkg::GLOBAL_CONFIG_OFS, 8'h01);
        rd(glb_regs_pkg::JITTER_CONFIG_OFS, 8'h00);
        chk("timer cleared", {31'h0, timer_irq}, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire

/* core/glb_regs_pkg.sv */
package glb_regs_pkg;
    localparam int ADDR_W = 11;
    localparam logic [10:0] PART_CODE_OFS = 11'h000;
    localparam logic [10:0] ERR_LOW_OFS = 11'h023;
    localparam logic [10:0] ERR_HIGH_OFS = 11'h024;
    localparam logic [10:0] SOFT_RESET_OFS = 11'h040;
    localparam logic [10:0] GLOBAL_CONFIG_OFS = 11'h041;
    localparam logic [10:0] JITTER_CONFIG_OFS = 11'h7E5;
    localparam logic [10:0] POS_LOW_OFS = 11'h7E6;
    localparam logic [10:0] POS_HIGH_OFS = 11'h7E7;
    localparam logic [10:0] NEG_LOW_OFS = 11'h7E8;
    localparam logic [10:0] NEG_HIGH_OFS = 11'h7E9;
    localparam logic [10:0] TIMER_STATUS_OFS = 11'h042;
    // Part code value is arbitrary; low nibble is the revision
    localparam logic [7:0] PART_CODE_VALUE = 8'h50;
    localparam logic [7:0] GLOBAL_CONFIG_RESET = 8'h01;
    localparam logic [7:0] JITTER_CONFIG_RESET = 8'h00;
    localparam int GCF_COPY_BIT = 4;
    localparam int GCF_PIN_LSB = 2;
    localparam int GCF_GLOBAL_INTERRUPT_MASK_BIT = 1;
    localparam int GCF_ONE_SECOND_TIMER_MASK_BIT = 0;
    localparam int JM_HALT_BIT = 2;
    localparam int JM_MODE_BIT = 1;
    localparam int JITTER_BANDWIDTH_BIT_BIT = 0;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int SOFT_RESET_MAX_NS = 1000;
    localparam int SOFT_RESET_CYCLES = (SOFT_RESET_MAX_NS * 1000) / CLK_PERIOD_PS / 2;
    localparam longint ONE_SECOND_PS = 64'd1000000000000;
    localparam int ONE_SECOND_CYCLES = int'(ONE_SECOND_PS / CLK_PERIOD_PS);
endpackage

/* core/global_control_and_measurement_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module global_control_and_measurement_regs #(
    parameter int CHANNELS = 28,
    parameter int ONE_SECOND_CYCLES = glb_regs_pkg::ONE_SECOND_CYCLES
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [10:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic [15:0] error_count,
    input wire logic [11:0] positive_peak,
    input wire logic [11:0] negative_peak,
    input wire logic [CHANNELS-1:0] channel_mask,
    input wire logic [CHANNELS-1:0] channel_status,
    output logic [CHANNELS-1:0] channel_irq,
    output logic timer_irq,
    output logic soft_reset,
    output logic jitter_halt_bit,
    output logic jitter_mode_bit,
    output logic jitter_bandwidth_bit,
    output logic copy_ctrl,
    output logic [1:0] int_pin_drive
);
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] gcf_reg;
    logic [2:0] jm_reg;
    logic [31:0] sec_count_reg;
    logic timer_flag_reg;
    logic [CHANNELS-1:0] irq_reg;
    logic [CHANNELS-1:0] irq_next;
    logic sreset;
    logic block_rst_n;
    logic sec_tick;
    logic wr_gcf;
    logic wr_jm;
    logic wr_rst;
    logic rd_timer;
    logic [7:0] gcf_wmask;

    function automatic logic hit(input logic [10:0] a, input logic [10:0] ofs);
        hit = (a == ofs);
    endfunction

    soft_reset_gen #(
        .CYCLES(glb_regs_pkg::SOFT_RESET_CYCLES)
    ) u_soft_reset (
        .core_clk(core_clk),
        .nrst(nrst),
        .trigger(wr_rst),
        .soft_reset(sreset)
    );

    // Data value ignored; only the strobe matters
    assign wr_rst = wr_en & hit(addr, glb_regs_pkg::SOFT_RESET_OFS);
    assign wr_gcf = wr_en & hit(addr, glb_regs_pkg::GLOBAL_CONFIG_OFS);
    assign wr_jm = wr_en & hit(addr, glb_regs_pkg::JITTER_CONFIG_OFS);
    assign rd_timer = rd_en & hit(addr, glb_regs_pkg::TIMER_STATUS_OFS);
    // Reserved bits 7 to 5 never store
    assign gcf_wmask = 8'h1F;
    // Soft reset held in its own module so it can clear the rest of the block
    assign block_rst_n = nrst & ~sreset;
    assign soft_reset = sreset;
    assign sec_tick = (sec_count_reg == 32'(ONE_SECOND_CYCLES - 1));
    assign irq_next = gcf_reg[glb_regs_pkg::GCF_GLOBAL_INTERRUPT_MASK_BIT] ? '0 : (~channel_mask & channel_status);

    always_comb
    begin
        rdata_next = 8'h00;
        case (addr)
            glb_regs_pkg::PART_CODE_OFS: rdata_next = glb_regs_pkg::PART_CODE_VALUE;
            glb_regs_pkg::ERR_LOW_OFS: rdata_next = error_count[7:0];
            glb_regs_pkg::ERR_HIGH_OFS: rdata_next = error_count[15:8];
            glb_regs_pkg::SOFT_RESET_OFS: rdata_next = 8'h00;
            glb_regs_pkg::GLOBAL_CONFIG_OFS: rdata_next = gcf_reg & gcf_wmask;
            glb_regs_pkg::TIMER_STATUS_OFS: rdata_next = {7'h00, timer_flag_reg};
            glb_regs_pkg::JITTER_CONFIG_OFS: rdata_next = {5'h00, jm_reg};
            glb_regs_pkg::POS_LOW_OFS: rdata_next = positive_peak[7:0];
            glb_regs_pkg::POS_HIGH_OFS: rdata_next = {4'h0, positive_peak[11:8]};
            glb_regs_pkg::NEG_LOW_OFS: rdata_next = negative_peak[7:0];
            glb_regs_pkg::NEG_HIGH_OFS: rdata_next = {4'h0, negative_peak[11:8]};
            default: rdata_next = 8'h00;
        endcase
        if (!rd_en)
        begin
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge core_clk or negedge block_rst_n)
    begin
        if (!block_rst_n)
        begin
            rdata_reg <= 8'h00;
            gcf_reg <= glb_regs_pkg::GLOBAL_CONFIG_RESET;
            jm_reg <= 3'h0;
            irq_reg <= '0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
            if (wr_gcf)
            begin
                gcf_reg <= wdata & gcf_wmask;
            end
            if (wr_jm)
            begin
                jm_reg <= wdata[2:0];
            end
        end
    end

    // Timer keeps time from core_clk; expiry flag is sticky and cleared by reading it
    always_ff @(posedge core_clk or negedge block_rst_n)
    begin
        if (!block_rst_n)
        begin
            sec_count_reg <= 32'h00000000;
            timer_flag_reg <= 1'b0;
        end
        else
        begin
            sec_count_reg <= sec_tick ? 32'h00000000 : sec_count_reg + 32'h00000001;
            // Expiry wins over a clearing read in the same cycle
            if (sec_tick && !gcf_reg[glb_regs_pkg::GCF_ONE_SECOND_TIMER_MASK_BIT])
            begin
                timer_flag_reg <= 1'b1;
            end
            else if (rd_timer)
            begin
                timer_flag_reg <= 1'b0;
            end
        end
    end

    assign rdata = rdata_reg;
    assign channel_irq = irq_reg;
    assign timer_irq = timer_flag_reg;
    assign jitter_halt_bit = jm_reg[glb_regs_pkg::JM_HALT_BIT];
    assign jitter_mode_bit = jm_reg[glb_regs_pkg::JM_MODE_BIT];
    assign jitter_bandwidth_bit = jm_reg[glb_regs_pkg::JITTER_BANDWIDTH_BIT_BIT];
    assign copy_ctrl = gcf_reg[glb_regs_pkg::GCF_COPY_BIT];
    assign int_pin_drive = gcf_reg[glb_regs_pkg::GCF_PIN_LSB +: 2];
endmodule
`default_nettype wire

/* core/soft_reset_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module soft_reset_gen #(
    parameter int CYCLES = 62
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic trigger,
    output logic soft_reset
);
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic active_reg;
    logic active_next;
    // Retrigger during a reset restarts the count
    assign count_next = trigger ? 8'(CYCLES) : (count_reg != 8'h00 ? count_reg - 8'h01 : 8'h00);
    assign active_next = trigger | (count_reg > 8'h01);
    assign soft_reset = active_reg;
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count_reg <= 8'h00;
            active_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            active_reg <= active_next;
        end
    end
endmodule
`default_nettype wire
